/* logic/sar_sequencer_defs.vh */
// constants for the successive-approximation conversion sequencer
`ifndef SAR_SEQUENCER_DEFS_VH
`define SAR_SEQUENCER_DEFS_VH
`define CODE_WIDTH 16
`define CODE_MSB_ONE 16'h8000
`define CODE_RESET 16'h0000
`define SYS_CLK_HZ 10000000
`define SETTLE_NS 100
`define SETTLE_CYCLES (((`SETTLE_NS * (`SYS_CLK_HZ / 1000000)) + 999) / 1000)
`define STEP_CNT_WIDTH 5
`define STEP_LAST 5'h0F
`define GRADE_2MSPS 2'h0
`define GRADE_1MSPS 2'h1
`define GRADE_500KSPS 2'h2
`endif

/* logic/sar_conversion_sequencer.v */
// successive-approximation conversion sequencer
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/10ps
`include "sar_sequencer_defs.vh"

module sar_conversion_sequencer #(
   parameter [1:0] SPEED_GRADE = `GRADE_2MSPS
) (
   // clock and reset
   input wire SYS_CLK,
   input wire RESETN,
   // host pins
   input wire CONVERT_START,
   input wire SERIAL_IN_MODE_SELECT,
   // configuration
   input wire LOW_CHARGE_EN,
   // comparator
   input wire COMPARATOR_OUT,
   // analog switch control
   output reg POSITIVE_ARRAY_GROUND_SWITCH,
   output reg NEGATIVE_ARRAY_GROUND_SWITCH,
   output reg ARRAYS_TO_INPUT,
   output reg [15:0] TRIAL_BITS,
   output reg CONVERTER_POWER_ON,
   output reg LOW_CHARGE_MODE,
   // result
   output reg [15:0] RESULT_CODE,
   output reg RESULT_VALID,
   output reg BUSY_INDICATOR,
   output reg CHAIN_MODE,
   output reg CONVERTING
);

// ---------------------------------------------------------------
// states
// ---------------------------------------------------------------
localparam [4:0] ST_ACQUIRE = 5'h01;
localparam [4:0] ST_OPEN_SW = 5'h02;
localparam [4:0] ST_HOLD = 5'h04;
localparam [4:0] ST_TRIAL = 5'h08;
localparam [4:0] ST_DONE = 5'h10;

// ---------------------------------------------------------------
// input synchronisers
// ---------------------------------------------------------------
wire cnv_level;
wire sdi_level;
reg cnv_prev_reg;
wire cnv_rise = cnv_level & ~cnv_prev_reg;

// convert pin, two flip-flops before any logic
pin_sync2 i_cnv_sync (
   .clk(SYS_CLK),
   .resetn(RESETN),
   .pin(CONVERT_START),
   .level(cnv_level)
);

// mode pin, two flip-flops before any logic
pin_sync2 i_sdi_sync (
   .clk(SYS_CLK),
   .resetn(RESETN),
   .pin(SERIAL_IN_MODE_SELECT),
   .level(sdi_level)
);

// previous convert level; resets to the idle low of the pin
always @(posedge SYS_CLK) begin
   if (!RESETN) begin
      cnv_prev_reg <= 1'b0;
   end else begin
      cnv_prev_reg <= cnv_level;
   end
end

// ---------------------------------------------------------------
// sequencer
// ---------------------------------------------------------------
reg [4:0] state_reg;
reg [4:0] state_next;
reg [4:0] step_reg;
reg [4:0] step_next;
reg [15:0] trial_next;
reg [15:0] weight_reg;
reg [15:0] weight_next;
reg [15:0] code_next;
reg valid_next;
reg busy_next;
reg chain_next;
reg cs_mode_reg;
reg cs_mode_next;

// ---------------------------------------------------------------
// next-state logic
// ---------------------------------------------------------------
always @* begin
   state_next = state_reg;
   step_next = step_reg;
   trial_next = TRIAL_BITS;
   weight_next = weight_reg;
   code_next = RESULT_CODE;
   valid_next = RESULT_VALID;
   busy_next = BUSY_INDICATOR;
   chain_next = CHAIN_MODE;
   cs_mode_next = cs_mode_reg;
   case (state_reg)
      ST_ACQUIRE: begin
         if (cnv_rise) begin
            state_next = ST_OPEN_SW;
            chain_next = ~sdi_level;
            cs_mode_next = sdi_level;
            busy_next = 1'b0;
         end
      end
      ST_OPEN_SW: begin
         // ground switches now open; arrays leave inputs next
         state_next = ST_HOLD;
      end
      ST_HOLD: begin
         state_next = ST_TRIAL;
         step_next = 5'h00;
         weight_next = `CODE_MSB_ONE;
         trial_next = `CODE_MSB_ONE;
      end
      ST_TRIAL: begin
         // keep bit if comparator says trial not above input
         if (COMPARATOR_OUT) begin
            trial_next = TRIAL_BITS & ~weight_reg;
         end else begin
            trial_next = TRIAL_BITS;
         end
         weight_next = weight_reg >> 1;
         trial_next = trial_next | (weight_reg >> 1);
         step_next = step_reg + 5'h01;
         if (step_reg == `STEP_LAST) begin
            state_next = ST_DONE;
         end
      end
      ST_DONE: begin
         code_next = TRIAL_BITS;
         valid_next = 1'b1;
         // busy indication gated in chip-select mode
         if (cs_mode_reg) begin
            busy_next = ~sdi_level | ~cnv_level;
         end else begin
            busy_next = 1'b1;
         end
         state_next = ST_ACQUIRE;
      end
      default: begin
         state_next = ST_ACQUIRE;
      end
   endcase
end

// ---------------------------------------------------------------
// sequencer registers
// ---------------------------------------------------------------
always @(posedge SYS_CLK) begin
   if (!RESETN) begin
      state_reg <= ST_ACQUIRE;
      step_reg <= 5'h00;
      weight_reg <= 16'h0000;
      cs_mode_reg <= 1'b0;
   end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      weight_reg <= weight_next;
      cs_mode_reg <= cs_mode_next;
   end
end

// ---------------------------------------------------------------
// trial and result outputs
// ---------------------------------------------------------------
// current capacitor-array setting
always @(posedge SYS_CLK) begin
   if (!RESETN) begin
      TRIAL_BITS <= 16'h0000;
   end else begin
      TRIAL_BITS <= trial_next;
   end
end

// code and valid flag stand until the next result; busy clears at the next start
always @(posedge SYS_CLK) begin
   if (!RESETN) begin
      RESULT_CODE <= `CODE_RESET;
      RESULT_VALID <= 1'b0;
      BUSY_INDICATOR <= 1'b0;
   end else begin
      RESULT_CODE <= code_next;
      RESULT_VALID <= valid_next;
      BUSY_INDICATOR <= busy_next;
   end
end

// ---------------------------------------------------------------
// readout mode
// ---------------------------------------------------------------
always @(posedge SYS_CLK) begin
   if (!RESETN) begin
      CHAIN_MODE <= 1'b0;
   end else begin
      CHAIN_MODE <= chain_next;
   end
end

// ---------------------------------------------------------------
// analog switch control
// ---------------------------------------------------------------
// switches closed only while acquiring
always @(posedge SYS_CLK) begin
   if (!RESETN) begin
      POSITIVE_ARRAY_GROUND_SWITCH <= 1'b1;
      NEGATIVE_ARRAY_GROUND_SWITCH <= 1'b1;
   end else begin
      POSITIVE_ARRAY_GROUND_SWITCH <= (state_next == ST_ACQUIRE);
      NEGATIVE_ARRAY_GROUND_SWITCH <= (state_next == ST_ACQUIRE);
   end
end

// arrays leave inputs one cycle after switches open
always @(posedge SYS_CLK) begin
   if (!RESETN) begin
      ARRAYS_TO_INPUT <= 1'b1;
   end else begin
      ARRAYS_TO_INPUT <= (state_next == ST_ACQUIRE) |
         (state_next == ST_OPEN_SW);
   end
end

// ---------------------------------------------------------------
// power and status
// ---------------------------------------------------------------
// converter powered only between start and result
always @(posedge SYS_CLK) begin
   if (!RESETN) begin
      CONVERTER_POWER_ON <= 1'b0;
   end else begin
      CONVERTER_POWER_ON <= (state_next != ST_ACQUIRE);
   end
end

// conversion runs from the system clock alone
always @(posedge SYS_CLK) begin
   if (!RESETN) begin
      CONVERTING <= 1'b0;
   end else begin
      CONVERTING <= (state_next != ST_ACQUIRE);
   end
end

// low-charge mode follows the configuration bit
always @(posedge SYS_CLK) begin
   if (!RESETN) begin
      LOW_CHARGE_MODE <= 1'b0;
   end else begin
      LOW_CHARGE_MODE <= LOW_CHARGE_EN;
   end
end

endmodule

// ---------------------------------------------------------------
// two-stage pin synchroniser
// ---------------------------------------------------------------
module pin_sync2 (
   // clock and reset
   input wire clk,
   input wire resetn,
   // asynchronous pin and its synchronised level
   input wire pin,
   output wire level
);

reg [1:0] sync_reg;

// only the second stage is read
assign level = sync_reg[1];

always @(posedge clk) begin
   if (!resetn) begin
      sync_reg <= 2'h0;
   end else begin
      sync_reg <= {sync_reg[0], pin};
   end
end

endmodule

/* test/sar_seq_checker.sv */
// port assertions for the conversion sequencer
`timescale 1ns/10ps
module sar_seq_checker (
   input wire SYS_CLK,
   RESETN,
   LOW_CHARGE_EN,
   POSITIVE_ARRAY_GROUND_SWITCH,
   NEGATIVE_ARRAY_GROUND_SWITCH,
   ARRAYS_TO_INPUT,
   CONVERTER_POWER_ON,
   LOW_CHARGE_MODE,
   RESULT_VALID,
   BUSY_INDICATOR,
   CONVERTING,
   input wire [15:0] TRIAL_BITS,
   RESULT_CODE
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   sequence hold8;
      CONVERTING [*8];
   endsequence
   sequence opened;
      !POSITIVE_ARRAY_GROUND_SWITCH && !NEGATIVE_ARRAY_GROUND_SWITCH;
   endsequence
   a_switch_order: assert property ($rose(CONVERTING) |->
      opened ##0 ARRAYS_TO_INPUT ##1 !ARRAYS_TO_INPUT) else $error("order");
   a_msb_first: assert property ($rose(CONVERTING) |->
      ##2 TRIAL_BITS == 16'h8000) else $error("first trial");
   a_conv_hold: assert property ($rose(CONVERTING) |->
      hold8 ##1 hold8 ##1 CONVERTING [*3]) else $error("early end");
   a_busy_end: assert property ($rose(CONVERTING) |->
      ##19 $fell(CONVERTING) && BUSY_INDICATOR) else $error("busy");
   a_power_idle: assert property (!CONVERTING ##1 !CONVERTING |->
      !CONVERTER_POWER_ON) else $error("power");
   a_valid_first: assert property ($fell(CONVERTING) |->
      RESULT_VALID) else $error("valid");
   a_code_held: assert property (CONVERTING |->
      $stable(RESULT_CODE)) else $error("code moved");
   a_low_charge: assert property ($past(RESETN) |->
      LOW_CHARGE_MODE == $past(LOW_CHARGE_EN)) else $error("mode");
endmodule
bind sar_conversion_sequencer sar_seq_checker i_sar_seq_checker (.*);

/* test/sar_host_model.sv */
// host controller model driving the convert and mode pins
`timescale 1ns/10ps
module sar_host_model (
   output logic CONVERT_START,
   output logic SERIAL_IN_MODE_SELECT
);
   initial begin
      CONVERT_START = 0;
      SERIAL_IN_MODE_SELECT = 1;
   end
   // no serial clock edges are made around a conversion
   // fast readout taken as enabled by the host
   task automatic convert(input logic cs_mode);
      SERIAL_IN_MODE_SELECT = cs_mode;
      #400 CONVERT_START = 1;
      #400 CONVERT_START = 0;
   endtask
endmodule

/* test/sar_conversion_sequencer_test.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module sar_conversion_sequencer_test;
   logic SYS_CLK = 0, RESETN = 0, LOW_CHARGE_EN = 0;
   logic [15:0] sample = 0;
   int err_count = 0, n_checks = 0;
   logic [16:0] rows [4] = '{17'h00000, 17'h1FFFF, 17'h08000, 17'h1A5C3};
   wire CONVERT_START, SERIAL_IN_MODE_SELECT, POSITIVE_ARRAY_GROUND_SWITCH;
   wire NEGATIVE_ARRAY_GROUND_SWITCH, ARRAYS_TO_INPUT, CONVERTER_POWER_ON;
   wire LOW_CHARGE_MODE, RESULT_VALID, BUSY_INDICATOR, CHAIN_MODE, CONVERTING;
   wire [15:0] TRIAL_BITS, RESULT_CODE;
   wire COMPARATOR_OUT = TRIAL_BITS > sample;
   sar_conversion_sequencer i_sar_conversion_sequencer (.*);
   sar_host_model i_sar_host_model (.*);
   initial forever #50 SYS_CLK = ~SYS_CLK;
   task check(input string what, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task test_done;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task run(input logic [16:0] row);
      sample = row[15:0];
      i_sar_host_model.convert(row[16]);
      do begin
         @(posedge SYS_CLK);
         #1;
      end while (CONVERTING === 1'b1);
   endtask
   initial begin
      repeat (16) @(posedge SYS_CLK);
      #1 RESETN = 1;
      check("idle", {12'h0, POSITIVE_ARRAY_GROUND_SWITCH, ARRAYS_TO_INPUT,
         RESULT_VALID, BUSY_INDICATOR}, 16'hC);
      foreach (rows[i]) begin
         LOW_CHARGE_EN = rows[i][0];
         run(rows[i]);
         check("code", RESULT_CODE, rows[i][15:0]);
         check("flags", {13'h0, BUSY_INDICATOR, RESULT_VALID, CHAIN_MODE},
            {15'h3, !rows[i][16]});
      end
      fork
         run(17'h11234);
         #600 i_sar_host_model.convert(1'b1);
      join
      check("ignored", {15'h0, CONVERTING}, 16'h0);
      repeat (10) @(posedge SYS_CLK);
      #1 check("idle after", {15'h0, CONVERTING}, 16'h0);
      check("kept code", RESULT_CODE, 16'h1234);
      test_done;
   end
   initial begin
      #100000 err_count++;
      test_done;
   end
endmodule
